//--- core_supply_fault_pkg.sv
package core_supply_fault_pkg;
   // -----------------------------------------------------------------
   // timing
   // -----------------------------------------------------------------
   // slew clock cycles of blanking after the final target code
   localparam logic [5:0] BLANK_SLEW_CYCLES = 6'h20;
   localparam int BLANK_CNT_W = 6;

   // -----------------------------------------------------------------
   // current limit
   // -----------------------------------------------------------------
   localparam int CURRENT_LIMIT_SET_FIXED_MV = 50;  // threshold with strap to logic supply
   localparam int CURRENT_LIMIT_SET_ADJ_DIV = 10;   // adjustable threshold = pin voltage / 10

   // -----------------------------------------------------------------
   // reset values
   // -----------------------------------------------------------------
   localparam logic PG_RESET = 1'b0;
   localparam logic CLK_GATE_RESET = 1'b0;

   // sticky fault latches
   typedef struct packed {
      logic ov;  // overvoltage
      logic uv;  // undervoltage
      logic ot;  // overtemperature
   } fault_flags_t;

   localparam fault_flags_t FAULTS_CLEAR = '{ov: 1'b0, uv: 1'b0, ot: 1'b0};

   // asynchronous analog and pin flags, synchronised as one bundle
   typedef struct packed {
      logic ov;         // output above target by the overvoltage margin
      logic uv;         // output below undervoltage fraction of nominal
      logic ot;         // overtemperature sensor, hysteresis in the sensor
      logic shutdown_input;       // shutdown input logic level
      logic test;       // shutdown input held in test voltage range
      logic tick;       // slew-rate clock
      logic trans;      // output-voltage transition in progress
      logic strap;      // current-limit pin strapped to logic supply
   } sense_t;

   localparam sense_t SENSE_CLEAR = '0;

   // normal-operation requests from the regulation loop
   typedef struct packed {
      logic hs;         // high-side gate request
      logic ls;         // low-side gate request
      logic pg;         // power good from the window comparators
      logic clk_gate;   // clock-enable request
   } loop_req_t;
endpackage : core_supply_fault_pkg

//--- core_supply_fault_supervisor.sv
`timescale 1ns/100ps
`default_nettype none
module core_supply_fault_supervisor
   import core_supply_fault_pkg::*;
(
   input wire logic clk,                                  // 100 MHz clock
   input wire logic rst_n,                                // supply power-on detect
   input wire core_supply_fault_pkg::sense_t sense_in,    // async flags and pins
   input wire core_supply_fault_pkg::loop_req_t loop_req, // loop requests
   output logic core_power_good,                          // power good to cpu
   output logic cpu_clock_gate,                           // cpu clock enable
   output logic low_side_gate,                            // low-side gate drive
   output logic high_side_gate,                           // high-side gate drive
   output logic pwm_disable,                              // pwm latched off
   output logic current_limit_fixed,                      // 1: fixed 50mV limit
   output var core_supply_fault_pkg::fault_flags_t fault_state // latched faults
);
   import core_supply_fault_pkg::*;

   sense_t meta_reg;
   sense_t sync_reg;
   logic shutdown_input_prev_reg;
   logic tick_prev_reg;
   logic trans_prev_reg;
   logic [BLANK_CNT_W-1:0] blank_cnt_reg;
   fault_flags_t lat_reg;
   fault_flags_t lat_next;
   logic ov_gate_reg;
   logic shutdown_input_toggle;
   logic tick_rise;
   logic trans_done;
   logic blank;

   // -----------------------------------------------------------------
   // input synchronisers
   // -----------------------------------------------------------------
   // all analog flags come from outside the clock domain; the chain runs
   // through reset so it already holds the pin levels when reset lets go
   always_ff @(posedge clk) begin
      meta_reg <= sense_in;
      sync_reg <= meta_reg;
   end

   // edge history, read only from the second stage; not reset, so a pin
   // that sits high across reset gives no false toggle or tick afterwards
   always_ff @(posedge clk) begin
      shutdown_input_prev_reg <= sync_reg.shutdown_input;
      tick_prev_reg <= sync_reg.tick;
      trans_prev_reg <= sync_reg.trans;
   end

   // either edge of shutdown counts as a toggle
   assign shutdown_input_toggle = sync_reg.shutdown_input ^ shutdown_input_prev_reg;
   assign tick_rise = sync_reg.tick & ~tick_prev_reg;
   assign trans_done = trans_prev_reg & ~sync_reg.trans;

   // -----------------------------------------------------------------
   // transition blanking
   // -----------------------------------------------------------------
   // counts slew clocks, not system clocks, so blanking tracks the slew rate
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         blank_cnt_reg <= '0;
      end else if (sync_reg.trans) begin
         blank_cnt_reg <= '0;
      end else if (trans_done) begin
         blank_cnt_reg <= BLANK_SLEW_CYCLES;
      end else if (tick_rise && blank_cnt_reg != '0) begin
         blank_cnt_reg <= blank_cnt_reg - 1'b1;
      end
   end

   assign blank = sync_reg.trans | trans_done | (blank_cnt_reg != '0);

   // -----------------------------------------------------------------
   // fault latches
   // -----------------------------------------------------------------
   // test mode beats everything; a new fault beats a shutdown toggle
   always_comb begin
      lat_next = lat_reg;
      if (shutdown_input_toggle) begin
         lat_next.ov = 1'b0;
         lat_next.uv = 1'b0;
         // still hot: thermal stays latched until the sensor clears
         lat_next.ot = sync_reg.ot;
      end
      if (sync_reg.ov) begin
         lat_next.ov = 1'b1;
      end
      if (sync_reg.uv && !blank) begin
         lat_next.uv = 1'b1;
      end
      if (sync_reg.ot) begin
         lat_next.ot = 1'b1;
      end
      if (sync_reg.test) begin
         lat_next = FAULTS_CLEAR;
      end
   end

   // supply reset clears the latches
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         lat_reg <= FAULTS_CLEAR;
      end else begin
         lat_reg <= lat_next;
      end
   end

   // low-side latch follows one cycle after power-good has dropped
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ov_gate_reg <= 1'b0;
      end else begin
         ov_gate_reg <= lat_reg.ov & ~sync_reg.test;
      end
   end

   // -----------------------------------------------------------------
   // power good and clock enable
   // -----------------------------------------------------------------
   // overvoltage overrides the freeze so the cpu is warned at once
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         core_power_good <= PG_RESET;
         cpu_clock_gate <= CLK_GATE_RESET;
      end else if (lat_reg.ov) begin
         core_power_good <= 1'b0;
         cpu_clock_gate <= 1'b1;
      end else if (!blank) begin
         core_power_good <= loop_req.pg;
         cpu_clock_gate <= loop_req.clk_gate;
      end
   end

   // -----------------------------------------------------------------
   // gate drive overrides
   // -----------------------------------------------------------------
   // thermal and overvoltage discharge the output through the low side
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         low_side_gate <= 1'b0;
         high_side_gate <= 1'b0;
         pwm_disable <= 1'b0;
      end else begin
         pwm_disable <= |lat_reg;
         if (lat_reg.ot || ov_gate_reg) begin
            low_side_gate <= 1'b1;
            high_side_gate <= 1'b0;
         end else if (|lat_reg) begin
            low_side_gate <= 1'b0;
            high_side_gate <= 1'b0;
         end else begin
            low_side_gate <= loop_req.ls;
            high_side_gate <= loop_req.hs & ~loop_req.ls;
         end
      end
   end

   // current-limit mode and fault status
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         current_limit_fixed <= 1'b0;
         fault_state <= FAULTS_CLEAR;
      end else begin
         current_limit_fixed <= sync_reg.strap;
         fault_state <= lat_reg;
      end
   end

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   ov_warn_cpu_a: assert property (lat_reg.ov |=> !core_power_good && cpu_clock_gate)
      else $error("overvoltage did not drop power good and raise clock enable");
   ov_low_side_a: assert property ($rose(lat_reg.ov) && !sync_reg.test
                                   |-> ##2 low_side_gate && !high_side_gate)
      else $error("overvoltage did not latch the low-side gate on");
   ov_detect_a: assert property (sync_reg.ov && !sync_reg.test |=> lat_reg.ov)
      else $error("overvoltage flag not latched");
   uv_pwm_off_a: assert property (lat_reg.uv |=> pwm_disable && !high_side_gate)
      else $error("undervoltage did not disable pwm");
   uv_gates_off_a: assert property (lat_reg.uv && !lat_reg.ot && !ov_gate_reg
                                    |=> !low_side_gate && !high_side_gate)
      else $error("undervoltage did not turn both gates off");
   uv_blanked_a: assert property (blank && !lat_reg.uv |=> !lat_reg.uv)
      else $error("undervoltage latched during blanking");
   blank_len_a: assert property (trans_done |=> blank_cnt_reg == BLANK_SLEW_CYCLES)
      else $error("blanking count not loaded at end of transition");
   thermal_gate_a: assert property (lat_reg.ot |=> low_side_gate && !high_side_gate)
      else $error("thermal fault gate override missing");
   thermal_hold_a: assert property (lat_reg.ot && sync_reg.ot && !sync_reg.test
                                    |=> lat_reg.ot)
      else $error("thermal fault released while still hot");
   test_clear_a: assert property (sync_reg.test |=> lat_reg == FAULTS_CLEAR)
      else $error("test mode did not clear fault latches");
   uv_hold_a: assert property (lat_reg.uv && !shutdown_input_toggle && !sync_reg.test |=> lat_reg.uv)
      else $error("undervoltage latch released without toggle");
   toggle_clear_a: assert property (shutdown_input_toggle && !sync_reg.ov && !sync_reg.test
                                    |=> !lat_reg.ov)
      else $error("shutdown toggle did not clear overvoltage latch");
   freeze_a: assert property (blank && !lat_reg.ov |=> $stable(core_power_good))
      else $error("power good changed during transition blanking");
   freeze_clk_a: assert property (blank && !lat_reg.ov |=> $stable(cpu_clock_gate))
      else $error("clock enable changed during transition blanking");
   strap_a: assert property (sync_reg.strap |=> current_limit_fixed)
      else $error("fixed current-limit mode not selected");
endmodule : core_supply_fault_supervisor
`default_nettype wire

//--- gate_driver_model.sv
`timescale 1ns/100ps
`default_nettype none
// -----------------------------------------------------------------
// external gate drivers: count shoot-through cycles
// -----------------------------------------------------------------
module gate_driver_model (
   input wire logic clk,                 // system clock
   input wire logic rst_n,               // supply power-on detect
   input wire logic high_side_gate,      // high-side drive seen by mosfet
   input wire logic low_side_gate,       // low-side drive seen by mosfet
   output logic [7:0] overlap_count      // cycles with both mosfets on
);
   // one phase only: the slave limit set above the master's and
   // balance-led slave limiting are board choices, not modelled here
   // both on would short the input rail, so any count here is a fault
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         overlap_count <= 8'h00;
      end else if (high_side_gate && low_side_gate) begin
         overlap_count <= overlap_count + 8'h01;
      end
   end
endmodule : gate_driver_model
`default_nettype wire

//--- testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import core_supply_fault_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   sense_t sense = SENSE_CLEAR;
   loop_req_t loop_req = '{hs: 1'b1, ls: 1'b0, pg: 1'b1, clk_gate: 1'b1};
   logic core_power_good, cpu_clock_gate, low_side_gate, high_side_gate;
   logic pwm_disable, current_limit_fixed;
   fault_flags_t fault_state;
   logic [7:0] overlap_count;
   logic [7:0] outs;
   int fails = 0;
   int num_checks = 0;
   int cycles = 0;
   // -----------------------------------------------------------------
   // clock, design and partner
   // -----------------------------------------------------------------
   always #5 clk = ~clk;
   assign outs = {core_power_good, cpu_clock_gate, low_side_gate, high_side_gate,
      pwm_disable, fault_state};
   core_supply_fault_supervisor u_core_supply_fault_supervisor (.clk(clk), .rst_n(rst_n),
      .sense_in(sense), .loop_req(loop_req), .core_power_good(core_power_good),
      .cpu_clock_gate(cpu_clock_gate), .low_side_gate(low_side_gate),
      .high_side_gate(high_side_gate), .pwm_disable(pwm_disable),
      .current_limit_fixed(current_limit_fixed), .fault_state(fault_state));
   gate_driver_model u_gate_driver_model (.clk(clk), .rst_n(rst_n),
      .high_side_gate(high_side_gate), .low_side_gate(low_side_gate),
      .overlap_count(overlap_count));
   // -----------------------------------------------------------------
   // tasks
   // -----------------------------------------------------------------
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : step
   // masked compare of the packed output word
   task automatic chk(input logic [7:0] exp, input logic [7:0] mask);
      num_checks++;
      if ((outs & mask) !== exp) begin
         fails++;
         $display("ERROR t=%0t got=%h exp=%h", $time, outs & mask, exp);
      end
   endtask : chk
   task automatic toggle_shutdown_input();
      @(posedge clk) sense.shutdown_input <= ~sense.shutdown_input;
      step(6);
   endtask : toggle_shutdown_input
   // slew clock: high three cycles, low three, so the synchroniser sees each edge
   task automatic ticks(input int n);
      repeat (n) begin
         @(posedge clk) sense.tick <= 1'b1;
         step(2);
         @(posedge clk) sense.tick <= 1'b0;
         step(2);
      end
   endtask : ticks
   task automatic drive(input logic ov, input logic uv, input logic ot, input int n);
      @(posedge clk);
      sense.ov <= ov;
      sense.uv <= uv;
      sense.ot <= ot;
      step(n);
   endtask : drive
   task automatic conclude();
      $display("checks=%0d mismatches=%0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : conclude
   // hang guard, well above the few hundred cycles the tests need
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         fails++;
         conclude();
      end
   end
   // -----------------------------------------------------------------
   // tests
   // -----------------------------------------------------------------
   initial begin
      step(5);
      chk(8'h00, 8'hFF);
      @(posedge clk) rst_n <= 1'b1;
      step(6);
      chk(8'hD0, 8'hFF);
      num_checks++;
      if (current_limit_fixed !== 1'b0) begin
         fails++;
         $display("ERROR t=%0t got=%h exp=%h", $time, current_limit_fixed, 1'b0);
      end
      @(posedge clk) sense.strap <= 1'b1;
      step(4);
      num_checks++;
      if (current_limit_fixed !== 1'b1) begin
         fails++;
         $display("ERROR t=%0t got=%h exp=%h", $time, current_limit_fixed, 1'b1);
      end
      $display("test reset and strap done");
      // overvoltage: power good drops before the low side turns on;
      // loop holds clock enable low so the forced high is visible
      @(posedge clk) loop_req.clk_gate <= 1'b0;
      drive(1'b1, 1'b0, 1'b0, 1);
      for (int i = 0; i < 10 && core_power_good !== 1'b0; i++) step(1);
      chk(8'h40, 8'hE0);
      step(3);
      chk(8'h6C, 8'hFF);
      drive(1'b0, 1'b0, 1'b0, 6);
      chk(8'h6C, 8'hFF);
      toggle_shutdown_input();
      chk(8'h90, 8'hFF);
      @(posedge clk) loop_req.clk_gate <= 1'b1;
      $display("test overvoltage done");
      // undervoltage latches pwm off with both gates low
      drive(1'b0, 1'b1, 1'b0, 6);
      chk(8'h0A, 8'h3F);
      drive(1'b0, 1'b0, 1'b0, 4);
      toggle_shutdown_input();
      chk(8'hD0, 8'hFF);
      $display("test undervoltage done");
      // blanking across a transition and 32 slew ticks after it
      @(posedge clk) sense.trans <= 1'b1;
      step(4);
      drive(1'b0, 1'b1, 1'b0, 1);
      @(posedge clk) begin
         loop_req.pg <= 1'b0;
         loop_req.clk_gate <= 1'b0;
      end
      ticks(3);
      chk(8'hD0, 8'hD7);
      @(posedge clk) sense.trans <= 1'b0;
      step(4);
      ticks(28);
      chk(8'hC0, 8'hC7);
      ticks(6);
      step(4);
      chk(8'h0A, 8'hFF);
      drive(1'b0, 1'b0, 1'b0, 2);
      @(posedge clk) begin
         loop_req.pg <= 1'b1;
         loop_req.clk_gate <= 1'b1;
      end
      toggle_shutdown_input();
      chk(8'hD0, 8'hFF);
      $display("test blanking done");
      // thermal fault holds until cooled and toggled
      drive(1'b0, 1'b0, 1'b1, 6);
      chk(8'h29, 8'h3F);
      toggle_shutdown_input();
      chk(8'h29, 8'h3F);
      drive(1'b0, 1'b0, 1'b0, 4);
      chk(8'h29, 8'h3F);
      toggle_shutdown_input();
      chk(8'hD0, 8'hFF);
      $display("test thermal done");
      // test mode: shutdown pin held in its high-voltage range
      drive(1'b1, 1'b0, 1'b0, 8);
      @(posedge clk) sense.test <= 1'b1;
      step(6);
      chk(8'hD0, 8'hFF);
      drive(1'b1, 1'b1, 1'b1, 8);
      chk(8'hD0, 8'hFF);
      drive(1'b0, 1'b0, 1'b0, 2);
      @(posedge clk) sense.test <= 1'b0;
      step(4);
      chk(8'hD0, 8'hFF);
      $display("test bypass done");
      // supply reset in mid-run clears a latched fault
      drive(1'b1, 1'b0, 1'b0, 8);
      chk(8'h6C, 8'hFF);
      @(posedge clk) begin
         sense.ov <= 1'b0;
         rst_n <= 1'b0;
      end
      step(4);
      chk(8'h00, 8'hFF);
      @(posedge clk) rst_n <= 1'b1;
      step(6);
      chk(8'hD0, 8'hFF);
      num_checks++;
      if (overlap_count !== 8'h00) begin
         fails++;
         $display("ERROR t=%0t got=%h exp=%h", $time, overlap_count, 8'h00);
      end
      $display("test reset clear done");
      conclude();
   end
endmodule : testbench
`default_nettype wire
